// ---- acm_channel_map.sv ----
// Behaviour
// - negative selector routes chosen source to minus
// - each channel map register sixteen bits wide
// - channel one map at 0x11, reset 0x0001
// - bit fifteen enables channel one, resets zero
// - two or more enabled channels sequence automatically
// - reserved bits read-only zero; software writes zero
// - bits 13:12 choose one of four setups
// - chosen setup applies all four setup registers
// - positive selector bits 9:5 route plus input
// - channel zero enable resets to one
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
module acm_channel_map
   import acm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic conv_done,
   output acm_route_t route,
   output logic [1:0] setup_apply,
   output logic setup_apply_stb,
   output logic in_range_err
);

   // ************************************************************
   // register file
   // ************************************************************
   logic [15:0] map_r [ACM_NCH]; // channel map registers
   logic [15:0] map_nxt [ACM_NCH]; // next channel map values
   logic [15:0] dwell_r; // conversion lasts this many cycles plus one when no done pulse
   logic [15:0] dwell_nxt; // next dwell
   logic [31:0] prdata_nxt; // read data muxed from the registers in the access phase
   logic pslverr_nxt; // error answered in the access phase
   logic [9:0] word_idx; // word index from the byte address
   logic acc; // access phase of a transfer
   logic mapped; // address hits a register

   assign word_idx = paddr[11:2];
   assign acc = psel & penable;
   assign pready = 1'b1; // zero wait state slave
   // read data and error stand during the access phase, so the master
   // takes them at the same edge that completes the transfer
   assign prdata = prdata_nxt;
   assign pslverr = pslverr_nxt;

   // sequencer state, declared here for the status read
   acm_state_t state_r; // sequencer state
   acm_state_t state_nxt; // next sequencer state
   logic cur_r; // channel being converted
   logic cur_nxt; // next channel
   logic [15:0] cnt_r; // dwell counter
   logic [15:0] cnt_nxt; // next dwell counter

   // decode, write and read next values
   always_comb begin
      map_nxt = map_r;
      dwell_nxt = dwell_r;
      prdata_nxt = 32'h0000_0000;
      pslverr_nxt = 1'b0;
      mapped = (word_idx == {2'b00, ACM_IDX_CH0_MAP}) ||
               (word_idx == {2'b00, ACM_IDX_CH1_MAP}) ||
               (word_idx == {2'b00, ACM_IDX_STATUS}) ||
               (word_idx == {2'b00, ACM_IDX_DWELL});
      if (acc) begin
         pslverr_nxt = ~mapped; // unmapped answers with an error
         if (pwrite) begin
            // reserved positions masked off so they stay zero
            if (word_idx == {2'b00, ACM_IDX_CH0_MAP}) begin
               map_nxt[0] = pwdata[15:0] & ACM_WR_MASK;
            end
            if (word_idx == {2'b00, ACM_IDX_CH1_MAP}) begin
               map_nxt[1] = pwdata[15:0] & ACM_WR_MASK;
            end
            if (word_idx == {2'b00, ACM_IDX_DWELL}) begin
               dwell_nxt = pwdata[15:0];
            end
         end else begin
            prdata_nxt = 32'h0000_0000;
            if (word_idx == {2'b00, ACM_IDX_CH0_MAP}) begin
               prdata_nxt[15:0] = map_r[0] & ACM_WR_MASK;
            end
            if (word_idx == {2'b00, ACM_IDX_CH1_MAP}) begin
               prdata_nxt[15:0] = map_r[1] & ACM_WR_MASK;
            end
            if (word_idx == {2'b00, ACM_IDX_STATUS}) begin
               prdata_nxt[3:0] = {in_range_err, route.valid, cur_r, state_r == ACM_CONV};
            end
            if (word_idx == {2'b00, ACM_IDX_DWELL}) begin
               prdata_nxt[15:0] = dwell_r;
            end
         end
      end
   end

   // register the bus side
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         map_r[0] <= ACM_CH0_RESET;
         map_r[1] <= ACM_CH1_RESET;
         dwell_r <= ACM_DWELL_RESET;
      end else begin
         map_r <= map_nxt;
         dwell_r <= dwell_nxt;
      end
   end

   // ************************************************************
   // channel sequencer
   // ************************************************************
   logic [ACM_NCH-1:0] en; // enable bits of every channel
   logic other_en; // the other channel is enabled
   logic step; // current conversion finished
   acm_route_t route_nxt; // next route
   logic stb_nxt; // next setup strobe

   assign en[0] = map_r[0][ACM_EN_BIT];
   assign en[1] = map_r[1][ACM_EN_BIT];
   assign other_en = en[~cur_r];
   assign step = conv_done || (cnt_r >= dwell_r);

   // choose next channel and build the route
   always_comb begin
      state_nxt = state_r;
      cur_nxt = cur_r;
      cnt_nxt = cnt_r + 16'h0001;
      unique case (state_r)
         ACM_IDLE: begin
            // start on the lowest enabled channel
            if (en != '0) begin
               state_nxt = ACM_CONV;
               cur_nxt = ~en[0];
               cnt_nxt = 16'h0000;
            end
         end
         ACM_CONV: begin
            if (en == '0) begin
               state_nxt = ACM_IDLE;
            end else if (step) begin
               // move on with no software action when another is on
               if (other_en) begin
                  cur_nxt = ~cur_r;
               end else if (!en[cur_r]) begin
                  state_nxt = ACM_IDLE;
               end
               cnt_nxt = 16'h0000;
            end
         end
      endcase
      route_nxt.valid = (state_nxt == ACM_CONV);
      route_nxt.chan = cur_nxt;
      // setup selection carries one of four setups
      route_nxt.setup = map_r[cur_nxt][ACM_SETUP_HI:ACM_SETUP_LO];
      route_nxt.pos_src = map_r[cur_nxt][ACM_POS_HI:ACM_POS_LO];
      route_nxt.neg_src = map_r[cur_nxt][ACM_NEG_HI:ACM_NEG_LO];
      // strobe applies the whole setup group on each new conversion
      stb_nxt = route_nxt.valid && ((state_r == ACM_IDLE) || step);
   end

   // register the sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ACM_IDLE;
         cur_r <= 1'b0;
         cnt_r <= 16'h0000;
         route <= '0;
         setup_apply <= 2'b00;
         setup_apply_stb <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cur_r <= cur_nxt;
         cnt_r <= cnt_nxt;
         route <= route_nxt;
         // setup only changes at a conversion start, never mid-conversion
         if (stb_nxt) begin
            setup_apply <= route_nxt.setup;
         end
         setup_apply_stb <= stb_nxt;
      end
   end

   // ************************************************************
   // source code check
   // ************************************************************
   // flags a route using a code outside the defined source set
   always_comb begin
      in_range_err = 1'b0;
      if (route.valid) begin
         in_range_err =
            !((route.pos_src <= ACM_SRC_IN4) || (route.pos_src == ACM_SRC_REFP) ||
              (route.pos_src == ACM_SRC_REFN)) ||
            !((route.neg_src <= ACM_SRC_IN4) || (route.neg_src == ACM_SRC_REFP) ||
              (route.neg_src == ACM_SRC_REFN));
      end
   end

endmodule // acm_channel_map

// ---- acm_channel_map_assertions.sv ----
`timescale 1ns/1ps
// ****************************************************************
// port checker for the channel map
// ****************************************************************
module acm_channel_map_assertions
   import acm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic conv_done,
   input wire acm_route_t route,
   input wire logic [1:0] setup_apply,
   input wire logic setup_apply_stb,
   input wire logic in_range_err
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic mapped; // address hits one of the four words
   logic pos_ok; // positive code is a documented source
   logic neg_ok; // negative code is a documented source
   assign mapped = (paddr[11:2] >= 10'h010) && (paddr[11:2] <= 10'h013);
   assign pos_ok = (route.pos_src <= ACM_SRC_IN4) || (route.pos_src inside {5'h15, 5'h16});
   assign neg_ok = (route.neg_src <= ACM_SRC_IN4) || (route.neg_src inside {5'h15, 5'h16});
   err_cause_a: assert property (psel && penable |-> pslverr == !mapped)
      else $error("error flag does not follow address decode");
   err_pulse_a: assert property (pslverr |-> psel && penable)
      else $error("error flag outside an access phase");
   upper_zero_a: assert property (prdata[31:16] == 16'h0000)
      else $error("read data above bit 15 not zero");
   resv_zero_a: assert property (psel && penable && !pwrite && paddr[11:3] == 9'h008
      |-> !prdata[14] && prdata[11:10] == 2'b00) else $error("reserved bits read nonzero");
   src_legal_a: assert property (in_range_err == !(pos_ok && neg_ok))
      else $error("range flag wrong for route codes");
   setup_hold_a: assert property (!setup_apply_stb |-> $stable(setup_apply))
      else $error("setup changed without a conversion start");
   chan_hold_a: assert property (route.valid && !setup_apply_stb |-> $stable(route.chan))
      else $error("channel changed without a conversion start");
   stb_match_a: assert property (setup_apply_stb |-> route.valid && setup_apply == route.setup)
      else $error("applied setup differs from route setup");
endmodule // acm_channel_map_assertions
bind acm_channel_map acm_channel_map_assertions u_chk (.*);

// ---- acm_pkg.sv ----
// ****************************************************************
// channel map package
// ****************************************************************
package acm_pkg;
   // register indices as printed; byte address is four times these
   localparam logic [7:0] ACM_IDX_CH0_MAP = 8'h10; // channel zero map index
   localparam logic [7:0] ACM_IDX_CH1_MAP = 8'h11; // channel one map index
   localparam logic [7:0] ACM_IDX_STATUS = 8'h12; // sequencer status index
   localparam logic [7:0] ACM_IDX_DWELL = 8'h13; // conversion dwell index
   // field layout
   localparam int ACM_EN_BIT = 15; // channel enable
   localparam int ACM_SETUP_HI = 13; // setup selector msb
   localparam int ACM_SETUP_LO = 12; // setup selector lsb
   localparam int ACM_POS_HI = 9; // positive selector msb
   localparam int ACM_POS_LO = 5; // positive selector lsb
   localparam int ACM_NEG_HI = 4; // negative selector msb
   localparam int ACM_NEG_LO = 0; // negative selector lsb
   // writable bits; bit 14 and bits 11:10 are reserved
   localparam logic [15:0] ACM_WR_MASK = 16'hb3ff;
   // reset values
   localparam logic [15:0] ACM_CH0_RESET = 16'h8001; // enabled, neg input one
   localparam logic [15:0] ACM_CH1_RESET = 16'h0001; // disabled, neg input one
   localparam logic [15:0] ACM_DWELL_RESET = 16'h0010; // cycles per conversion, less one
   // analog source codes
   localparam logic [4:0] ACM_SRC_IN0 = 5'h00; // analog_input_zero
   localparam logic [4:0] ACM_SRC_IN4 = 5'h04; // analog_input_four
   localparam logic [4:0] ACM_SRC_REFP = 5'h15; // positive reference
   localparam logic [4:0] ACM_SRC_REFN = 5'h16; // negative reference
   localparam int ACM_NCH = 2; // channels in this map

   // ************************************************************
   // route and setup carried to the converter
   // ************************************************************
   typedef struct packed {
      logic valid; // a channel is being converted
      logic chan; // channel number
      logic [1:0] setup; // setup to apply (all four registers)
      logic [4:0] pos_src; // positive input source
      logic [4:0] neg_src; // negative input source
   } acm_route_t;

   // sequencer states
   typedef enum logic [1:0] {
      ACM_IDLE = 2'b00,
      ACM_CONV = 2'b01
   } acm_state_t;
endpackage

// ---- adc_channel_map_config_tb_top.sv ----
`timescale 1ns/1ps
// ****************************************************************
// queue-checked bench for the channel map
// ****************************************************************
module adc_channel_map_config_tb_top;
   import acm_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, conv_done, pready, pslverr, stb, in_range_err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, lfsr;
   logic [1:0] setup_apply;
   acm_route_t route;
   logic [32:0] exp_q[$]; // {error, read data} per access
   logic [15:0] mv[2]; // map values written
   int error_cnt, n_compared, k;
   logic pc; // channel of last start
   acm_channel_map u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .conv_done(conv_done), .route(route), .setup_apply(setup_apply),
      .setup_apply_stb(stb), .in_range_err(in_range_err));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic summarize;
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // one apb transfer; note expectation, hold until pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic er, input logic [31:0] x);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      exp_q.push_back({er, x});
      for (n = 0; n < 50; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n == 50) begin
         error_cnt++;
         summarize();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // wait for a conversion start with random converter done pulses
   task automatic wait_stb;
      int n;
      for (n = 0; n < 200; n++) begin
         @(posedge pclk);
         lfsr = nxt(lfsr);
         conv_done <= lfsr[0] & lfsr[1];
         #1;
         if (stb === 1'b1) break;
      end
      conv_done <= 1'b0;
      if (n == 200) begin
         error_cnt++;
         summarize();
      end
   endtask
   // monitor: compare each finished access with the oldest note
   always @(posedge pclk) begin : mon
      logic [32:0] e;
      logic rd;
      if (presetn && psel && penable && pready) begin
         e = exp_q.pop_front();
         rd = !pwrite;
         chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
         if (rd && !e[32]) chk("prdata", e[31:0], prdata);
      end
   end
   initial begin
      {psel, penable, pwrite, conv_done, presetn} = 5'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      lfsr = 32'hd918;
      error_cnt = 0;
      n_compared = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      #1;
      chk("route0", {18'h0, 14'h2001}, {18'h0, route});
      @(posedge pclk);
      apb(0, 12'h040, 0, 0, {16'h0, ACM_CH0_RESET});
      apb(0, 12'h044, 0, 0, 32'h0001);
      apb(1, 12'h044, 32'hffff_ffff, 0, 0);
      apb(0, 12'h044, 0, 0, 32'hb3ff);
      for (k = 0; k < 8; k++) begin
         lfsr = nxt(lfsr);
         apb(1, 12'h044, {16'h0, lfsr[15:0] & ACM_WR_MASK}, 0, 0);
         apb(0, 12'h044, 0, 0, {16'h0, lfsr[15:0] & ACM_WR_MASK});
      end
      apb(1, 12'h080, 32'h1234, 1, 0);
      apb(0, 12'h03c, 0, 1, 0);
      mv[0] = 16'h8043;
      mv[1] = 16'h92b6;
      apb(1, 12'h040, {16'h0, mv[0]}, 0, 0);
      apb(1, 12'h044, {16'h0, mv[1]}, 0, 0);
      for (k = 0; k < 7; k++) begin
         wait_stb();
         if (k > 0) chk("alternate", {31'h0, ~pc}, {31'h0, route.chan});
         pc = route.chan;
         chk("route", {18'h0, 1'b1, pc, mv[pc][13:12], mv[pc][9:0]},
            {18'h0, route});
         chk("setup", {30'h0, mv[pc][13:12]}, {30'h0, setup_apply});
      end
      @(posedge pclk);
      apb(1, 12'h044, 32'h0001, 0, 0);
      for (k = 0; k < 4; k++) begin
         wait_stb();
         if (k > 0) chk("chan", 32'h0, {31'h0, route.chan});
      end
      summarize();
   end
endmodule // adc_channel_map_config_tb_top
